// File: core/rtc_supply_pkg.sv
/*
 * Shared constants and types for the supply supervisor: register offsets,
 * bit positions, timing counts, power states and carrier structs.
 * Assumes a 10 MHz system clock and byte-wide registers.
 */
`default_nettype none
package rtc_supply_pkg;
    localparam int CLK_PERIOD_NS = 100;

    localparam logic [7:0] ADDR_SECONDS_HALT = 8'h01;
    localparam logic [7:0] ADDR_CENTURY_HOURS = 8'h03;
    localparam logic [7:0] ADDR_RECOVERY_DAY = 8'h04;
    localparam logic [7:0] ADDR_CONTROL = 8'h08;
    localparam logic [7:0] ADDR_WATCHDOG = 8'h09;
    localparam logic [7:0] ADDR_ALARM_CTRL = 8'h0a;
    localparam logic [7:0] ADDR_HALT_UPDATE = 8'h0c;
    localparam logic [7:0] ADDR_FLAGS = 8'h0f;

    localparam int BIT_OSC_HALT = 7;
    localparam int BIT_CENTURY_EN = 7;
    localparam int BIT_CENTURY_TOGGLE = 6;
    localparam int BIT_RECOVERY_SEL = 7;
    localparam int BIT_OUT_LEVEL = 7;
    localparam int BIT_FREQ_TEST = 6;
    localparam int BIT_WD_STEERING = 7;
    localparam int BIT_ALARM_FLAG_EN = 7;
    localparam int BIT_SQUARE_WAVE_EN = 6;
    localparam int BIT_BACKUP_ALARM_EN = 5;
    localparam int BIT_HALT_UPDATE = 6;
    localparam int BIT_BATT_LOW = 4;

    localparam logic [7:0] WATCHDOG_CLEARED = 8'h00;

    // Shortest legal deselect interval of each mode, rounded up to cycles.
    localparam int REC_NORMAL_MIN_MS = 96;
    localparam int REC_HALT_MIN_MS = 40;
    localparam int REC_FAST_MIN_US = 50;
    localparam int REC_NORMAL_CYCLES =
        (REC_NORMAL_MIN_MS * 1000000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int REC_HALT_CYCLES =
        (REC_HALT_MIN_MS * 1000000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int REC_FAST_CYCLES =
        (REC_FAST_MIN_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int REC_CNT_W = 24;

    localparam int BATT_CHECK_HOURS = 24;
    localparam int BATT_CNT_W = 48;
    localparam logic [BATT_CNT_W-1:0] BATT_CHECK_CYCLES = BATT_CNT_W'(
        64'(BATT_CHECK_HOURS) * 64'd3600000000000 / 64'(CLK_PERIOD_NS));

    // Extra cycles the fail output stays forced high after the cycle in which power returns.
    localparam logic [1:0] PFO_RECOG_CYCLES = 2'h3;

    typedef enum logic [1:0] {
        PWR_BACKUP = 2'b00,
        PWR_RECOVER = 2'b01,
        PWR_NORMAL = 2'b10
    } pwr_state_t;

    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] wdata;
        logic wr;
        logic rd;
    } reg_req_t;

    typedef struct packed {
        logic supply_sense_low;
        logic supply_good;
        logic battery_low;
        logic battery_retained;
    } sense_t;
endpackage
`default_nettype wire

// File: core/recovery_timer.sv
/*
 * Post power-up write deselect timer; one start pulse gives one done pulse.
 * Assumes the mode bits are stable when start is pulsed.
 */
`default_nettype none
module recovery_timer
    import rtc_supply_pkg::*;
#(
    parameter int NORMAL_CYCLES = REC_NORMAL_CYCLES,
    parameter int HALT_CYCLES = REC_HALT_CYCLES,
    parameter int FAST_CYCLES = REC_FAST_CYCLES
) (
    input wire logic sys_clk_i,
    input wire logic reset_n_i,
    input wire logic start_i,
    input wire logic recovery_sel_i,
    input wire logic osc_halt_i,
    output logic done_o
);
    typedef struct packed {
        logic [REC_CNT_W-1:0] cnt;
        logic busy;
        logic done;
    } timer_state_t;

    timer_state_t st_reg;
    timer_state_t st_next;

    always_comb begin
        st_next = st_reg;
        st_next.done = 1'b0;
        if (start_i) begin
            st_next.busy = 1'b1;
            if (recovery_sel_i) begin
                st_next.cnt = REC_CNT_W'(FAST_CYCLES - 1);
            end else if (osc_halt_i) begin
                st_next.cnt = REC_CNT_W'(HALT_CYCLES - 1);
            end else begin
                st_next.cnt = REC_CNT_W'(NORMAL_CYCLES - 1);
            end
        end else if (st_reg.busy) begin
            if (st_reg.cnt == '0) begin
                st_next.busy = 1'b0;
                st_next.done = 1'b1;
            end else begin
                st_next.cnt = st_reg.cnt - 1'b1;
            end
        end
    end

    always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end

    assign done_o = st_reg.done;
endmodule
`default_nettype wire

// File: core/rtc_supervisor_power_control.sv
/*
 * Power supervisor of the clock chip: fail output gating, century toggle,
 * event pin driver, battery checks, recovery deselect and power-up defaults.
 * Assumes digital comparator results on pins and a byte register port.
 */
`default_nettype none
module rtc_supervisor_power_control
    import rtc_supply_pkg::*;
#(
    parameter int NORMAL_CYCLES = REC_NORMAL_CYCLES,
    parameter int HALT_CYCLES = REC_HALT_CYCLES,
    parameter int FAST_CYCLES = REC_FAST_CYCLES,
    parameter logic [BATT_CNT_W-1:0] BATT_CYCLES = BATT_CHECK_CYCLES
) (
    input wire logic sys_clk_i,
    input wire logic reset_n_i,
    input wire logic supply_sense_low_i,
    input wire logic supply_good_i,
    input wire logic battery_low_i,
    input wire logic battery_retained_i,
    input wire logic century_rollover_i,
    input wire logic wd_reset_timeout_i,
    input wire logic event_core_low_i,
    input wire logic event_pin_i,
    input wire reg_req_t reg_req_i,
    output logic [7:0] reg_rdata_o,
    output logic supply_fail_o,
    output logic write_deselect_o,
    output logic event_pin_o,
    output logic event_pin_oe_o
);
    typedef struct packed {
        sense_t s1;
        sense_t s2;
        sense_t s3;
        sense_t sense;
        pwr_state_t pwr;
        logic [1:0] pfo_cnt;
        logic [BATT_CNT_W-1:0] batt_cnt;
        logic rec_start;
        logic osc_halt;
        logic century_en;
        logic century_toggle;
        logic recovery_sel;
        logic [7:0] control;
        logic [7:0] watchdog;
        logic afe;
        logic square_wave_enable;
        logic abe;
        logic halt_update;
        logic batt_low;
        logic supply_fail_output;
        logic deselect;
        logic event_oe;
        logic event_data;
        logic [7:0] rdata;
    } state_t;
    state_t st_reg;
    state_t st_next;
    logic rec_done;
    default clocking cb_sys @(posedge sys_clk_i);
    endclocking
    default disable iff (!reset_n_i);

    function automatic logic [7:0] read_reg(input state_t s, input logic [7:0] a);
        logic [7:0] d;
        d = 8'h00;
        unique case (a)
            ADDR_SECONDS_HALT: d = 8'(s.osc_halt) << BIT_OSC_HALT;
            ADDR_CENTURY_HOURS: d = (8'(s.century_en) << BIT_CENTURY_EN)
                                  | (8'(s.century_toggle) << BIT_CENTURY_TOGGLE);
            ADDR_RECOVERY_DAY: d = 8'(s.recovery_sel) << BIT_RECOVERY_SEL;
            ADDR_CONTROL: d = s.control;
            ADDR_WATCHDOG: d = s.watchdog;
            ADDR_ALARM_CTRL: d = (8'(s.afe) << BIT_ALARM_FLAG_EN)
                               | (8'(s.square_wave_enable) << BIT_SQUARE_WAVE_EN)
                               | (8'(s.abe) << BIT_BACKUP_ALARM_EN);
            ADDR_HALT_UPDATE: d = 8'(s.halt_update) << BIT_HALT_UPDATE;
            ADDR_FLAGS: d = 8'(s.batt_low) << BIT_BATT_LOW;
            default: d = 8'h00;
        endcase
        return d;
    endfunction
    recovery_timer #(
        .NORMAL_CYCLES(NORMAL_CYCLES),
        .HALT_CYCLES(HALT_CYCLES),
        .FAST_CYCLES(FAST_CYCLES)
    ) u_recovery_timer (
        .sys_clk_i(sys_clk_i),
        .reset_n_i(reset_n_i),
        .start_i(st_reg.rec_start),
        .recovery_sel_i(st_reg.recovery_sel),
        .osc_halt_i(st_reg.osc_halt),
        .done_o(rec_done)
    );

    always_comb begin
        st_next = st_reg;
        st_next.rec_start = 1'b0;
        // Three-stage capture; a bit moves only when stages two and three agree.
        st_next.s1 = '{supply_sense_low_i, supply_good_i, battery_low_i,
                       battery_retained_i};
        st_next.s2 = st_reg.s1;
        st_next.s3 = st_reg.s2;
        st_next.sense = (~(st_reg.s2 ^ st_reg.s3) & st_reg.s3)
                      | ((st_reg.s2 ^ st_reg.s3) & st_reg.sense);
        unique case (st_reg.pwr)
            PWR_BACKUP: begin
                st_next.supply_fail_output = 1'b0;
                st_next.deselect = 1'b1;
                st_next.batt_cnt = '0;
                if (st_reg.sense.supply_good) begin
                    st_next.pwr = PWR_RECOVER;
                    st_next.rec_start = 1'b1;
                    st_next.supply_fail_output = 1'b1;
                    st_next.pfo_cnt = 2'h0;
                    st_next.batt_low = st_reg.sense.battery_low;
                    if (!st_reg.sense.battery_retained) begin
                        st_next.recovery_sel = 1'b0;
                        st_next.osc_halt = 1'b1;
                        st_next.control[BIT_OUT_LEVEL] = 1'b1;
                    end
                    // Other bits are left as they are; they count as undefined.
                    st_next.halt_update = 1'b1;
                    st_next.control[BIT_FREQ_TEST] = 1'b0;
                    st_next.afe = 1'b0;
                    st_next.abe = 1'b0;
                    st_next.square_wave_enable = 1'b0;
                    st_next.watchdog = WATCHDOG_CLEARED;
                end
            end
            PWR_RECOVER: begin
                st_next.deselect = 1'b1;
                if (st_reg.pfo_cnt != PFO_RECOG_CYCLES) begin
                    st_next.pfo_cnt = st_reg.pfo_cnt + 2'h1;
                    st_next.supply_fail_output = 1'b1;
                end else begin
                    st_next.supply_fail_output = ~st_reg.sense.supply_sense_low;
                end
                if (!st_reg.sense.supply_good) begin
                    st_next.pwr = PWR_BACKUP;
                    st_next.supply_fail_output = 1'b0;
                end else if (rec_done) begin
                    st_next.pwr = PWR_NORMAL;
                    st_next.deselect = 1'b0;
                end
            end
            PWR_NORMAL: begin
                st_next.supply_fail_output = ~st_reg.sense.supply_sense_low;
                if (st_reg.batt_cnt >= BATT_CYCLES - 1'b1) begin
                    st_next.batt_cnt = '0;
                    st_next.batt_low = st_reg.sense.battery_low;
                end else begin
                    st_next.batt_cnt = st_reg.batt_cnt + 1'b1;
                end
                if (!st_reg.sense.supply_good) begin
                    st_next.pwr = PWR_BACKUP;
                    st_next.supply_fail_output = 1'b0;
                    st_next.deselect = 1'b1;
                end
            end
            default: st_next.pwr = PWR_BACKUP;
        endcase
        // Writes land only with the supply up and the deselect interval over.
        if (reg_req_i.wr && st_reg.pwr == PWR_NORMAL) begin
            unique case (reg_req_i.addr)
                ADDR_SECONDS_HALT: st_next.osc_halt = reg_req_i.wdata[BIT_OSC_HALT];
                ADDR_CENTURY_HOURS: begin
                    st_next.century_en = reg_req_i.wdata[BIT_CENTURY_EN];
                    st_next.century_toggle = reg_req_i.wdata[BIT_CENTURY_TOGGLE];
                end
                ADDR_RECOVERY_DAY: begin
                    st_next.recovery_sel = reg_req_i.wdata[BIT_RECOVERY_SEL];
                end
                ADDR_CONTROL: st_next.control = reg_req_i.wdata;
                ADDR_WATCHDOG: st_next.watchdog = reg_req_i.wdata;
                ADDR_ALARM_CTRL: begin
                    st_next.afe = reg_req_i.wdata[BIT_ALARM_FLAG_EN];
                    st_next.square_wave_enable = reg_req_i.wdata[BIT_SQUARE_WAVE_EN];
                    st_next.abe = reg_req_i.wdata[BIT_BACKUP_ALARM_EN];
                end
                ADDR_HALT_UPDATE: st_next.halt_update = reg_req_i.wdata[BIT_HALT_UPDATE];
                default: begin
                end
            endcase
        end
        // Hardware events are applied after the write so that they win.
        if (century_rollover_i && st_next.century_en) begin
            st_next.century_toggle = ~st_next.century_toggle;
        end
        if (wd_reset_timeout_i && st_reg.watchdog[BIT_WD_STEERING]) begin
            st_next.watchdog = WATCHDOG_CLEARED;
            st_next.control[BIT_FREQ_TEST] = 1'b0;
            st_next.afe = 1'b0;
            st_next.abe = 1'b0;
            st_next.square_wave_enable = 1'b0;
        end
        if (!st_next.control[BIT_FREQ_TEST] && !st_next.afe
            && st_next.watchdog == WATCHDOG_CLEARED) begin
            st_next.event_oe = ~st_next.control[BIT_OUT_LEVEL];
        end else begin
            st_next.event_oe = event_core_low_i;
        end
        if (reg_req_i.rd) begin
            st_next.rdata = read_reg(st_reg, reg_req_i.addr);
        end
    end
    always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            st_reg <= '0;
            st_reg.deselect <= 1'b1;
            // Output level starts at one so the idle pin stays released after reset.
            st_reg.control[BIT_OUT_LEVEL] <= 1'b1;
        end else begin
            st_reg <= st_next;
        end
    end
    assign reg_rdata_o = st_reg.rdata;
    assign supply_fail_o = st_reg.supply_fail_output;
    assign write_deselect_o = st_reg.deselect;
    // The open-drain data bit never leaves zero; only the enable moves the pin.
    assign event_pin_o = st_reg.event_data;
    assign event_pin_oe_o = st_reg.event_oe;

    sequence s_power_return;
        st_reg.pwr == PWR_BACKUP && st_reg.sense.supply_good;
    endsequence
    property p_fail_follows;
        (st_reg.pwr == PWR_NORMAL && st_reg.sense.supply_good)
            |=> supply_fail_o == !$past(st_reg.sense.supply_sense_low);
    endproperty
    a_fail_follows: assert property (p_fail_follows) else $error("fail output not following");
    property p_backup_low;
        (st_reg.pwr != PWR_BACKUP && !st_reg.sense.supply_good)
            |=> !supply_fail_o && write_deselect_o ##1 !supply_fail_o;
    endproperty
    a_backup_low: assert property (p_backup_low) else $error("fail output not low in backup");
    property p_forced_high;
        s_power_return |=> supply_fail_o && st_reg.pwr == PWR_RECOVER;
    endproperty
    a_forced_high: assert property (p_forced_high) else $error("fail output not forced high");
    property p_century;
        (century_rollover_i && !reg_req_i.wr)
            |=> st_reg.century_toggle == ($past(st_reg.century_toggle) ^ $past(st_reg.century_en));
    endproperty
    a_century: assert property (p_century) else $error("century toggle wrong");
    property p_event_pin;
        (!st_reg.control[BIT_FREQ_TEST] && !st_reg.afe && st_reg.watchdog == WATCHDOG_CLEARED)
            |-> event_pin_oe_o == !st_reg.control[BIT_OUT_LEVEL];
    endproperty
    a_event_pin: assert property (p_event_pin) else $error("event pin not from level bit");
    property p_powerup_check;
        s_power_return |=> st_reg.batt_low == $past(st_reg.sense.battery_low) && st_reg.halt_update;
    endproperty
    a_powerup_check: assert property (p_powerup_check) else $error("power-up battery check missed");
    property p_no_backup_test;
        (st_reg.pwr == PWR_BACKUP && !st_reg.sense.supply_good) |=> $stable(st_reg.batt_low);
    endproperty
    a_no_backup_test: assert property (p_no_backup_test) else $error("battery tested in backup");
    property p_write_blocked;
        (reg_req_i.wr && !wd_reset_timeout_i && (st_reg.pwr == PWR_RECOVER
            || (st_reg.pwr == PWR_BACKUP && !st_reg.sense.supply_good)))
            |=> $stable(st_reg.recovery_sel) && $stable(st_reg.control);
    endproperty
    a_write_blocked: assert property (p_write_blocked) else $error("write during deselect");
    property p_initial_defaults;
        (s_power_return and !st_reg.sense.battery_retained)
            |=> st_reg.osc_halt && !st_reg.recovery_sel && st_reg.control[BIT_OUT_LEVEL]
                && st_reg.watchdog == WATCHDOG_CLEARED && !st_reg.square_wave_enable;
    endproperty
    a_initial_defaults: assert property (p_initial_defaults) else $error("bad initial defaults");
    property p_later_defaults;
        (s_power_return and st_reg.sense.battery_retained)
            |=> $stable(st_reg.recovery_sel) && $stable(st_reg.osc_halt) && !st_reg.afe;
    endproperty
    a_later_defaults: assert property (p_later_defaults) else $error("bad later defaults");
    property p_wd_clear;
        (wd_reset_timeout_i && st_reg.watchdog[BIT_WD_STEERING])
            |=> st_reg.watchdog == WATCHDOG_CLEARED && !st_reg.abe && !st_reg.control[BIT_FREQ_TEST];
    endproperty
    a_wd_clear: assert property (p_wd_clear) else $error("watchdog time-out did not clear");
endmodule
`default_nettype wire

// File: verification/supply_divider_model.sv
/*
 * Far-side model: supply rail detector, sense divider and backup battery.
 * Assumes the bench commands each level as a bit; pins move off the clock grid.
 */
`default_nettype none
module supply_divider_model (
    input wire logic rail_up_i,
    input wire logic sense_low_i,
    input wire logic batt_low_i,
    input wire logic retained_i,
    output logic supply_good_o,
    output logic supply_sense_low_o,
    output logic battery_low_o,
    output logic battery_retained_o
);
    timeunit 1ns;
    timeprecision 1ns;
    initial begin
        supply_good_o = 1'b0;
        supply_sense_low_o = 1'b0;
        battery_low_o = 1'b0;
        battery_retained_o = 1'b0;
    end
    // Comparators are analog, so their digital results land at arbitrary times.
    always @(rail_up_i, sense_low_i, batt_low_i, retained_i) begin
        supply_good_o <= #37 rail_up_i;
        supply_sense_low_o <= #23 sense_low_i;
        battery_low_o <= #41 batt_low_i;
        battery_retained_o <= #11 retained_i;
    end
endmodule
`default_nettype wire

// File: verification/rtc_supervisor_power_control_tb.sv
/*
 * Self-checking bench for the supply supervisor with a register model.
 * Assumes short deselect and battery intervals set through parameters.
 */
`default_nettype none
module rtc_supervisor_power_control_tb
    import rtc_supply_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    localparam int N_CY = 60;
    localparam int H_CY = 30;
    localparam int F_CY = 5;
    localparam int B_CY = 50;
    logic clk = 1'b0;
    logic reset_n = 1'b0;
    logic rail_up = 1'b0;
    logic sense_low = 1'b0;
    logic batt_low = 1'b1;
    logic retained = 1'b0;
    logic rollover = 1'b0;
    logic wd_timeout = 1'b0;
    logic core_low = 1'b0;
    reg_req_t req = '0;
    logic good_w, sense_w, batt_w, ret_w, fail, deselect, ev_o, ev_oe, ev_pin;
    logic [7:0] rdata;
    int n_mismatch = 0;
    int n_compared = 0;
    logic [31:0] seed = 32'ha50d;
    bit normal = 1'b0;
    logic [7:0] mreg [16] = '{default: 8'h00};
    logic [7:0] mask [16] = '{8'h00, 8'h80, 8'h00, 8'hc0, 8'h80, 8'h00, 8'h00, 8'h00,
                              8'hff, 8'hff, 8'he0, 8'h00, 8'h40, 8'h00, 8'h00, 8'h10};
    // The event pin is open drain with a pull-up on the board.
    assign ev_pin = ev_oe ? ev_o : 1'b1;
    supply_divider_model i_far (.rail_up_i(rail_up), .sense_low_i(sense_low),
        .batt_low_i(batt_low), .retained_i(retained), .supply_good_o(good_w),
        .supply_sense_low_o(sense_w), .battery_low_o(batt_w), .battery_retained_o(ret_w));
    rtc_supervisor_power_control #(.NORMAL_CYCLES(N_CY), .HALT_CYCLES(H_CY),
        .FAST_CYCLES(F_CY), .BATT_CYCLES(BATT_CNT_W'(B_CY))) i_dut (
        .sys_clk_i(clk), .reset_n_i(reset_n), .supply_sense_low_i(sense_w),
        .supply_good_i(good_w), .battery_low_i(batt_w), .battery_retained_i(ret_w),
        .century_rollover_i(rollover), .wd_reset_timeout_i(wd_timeout),
        .event_core_low_i(core_low), .event_pin_i(ev_pin), .reg_req_i(req),
        .reg_rdata_o(rdata), .supply_fail_o(fail), .write_deselect_o(deselect),
        .event_pin_o(ev_o), .event_pin_oe_o(ev_oe));
    initial begin
        forever #50 clk = ~clk;
    end
    function automatic logic [31:0] xs();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction
    task automatic conclude();
        $display("compared %0d mismatched %0d", n_compared, n_mismatch);
        if (n_mismatch == 0 && n_compared > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    task automatic step();
        @(posedge clk);
        #1;
    endtask
    task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
        n_compared++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("BAD %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        step();
        req.addr = a;
        req.wdata = d;
        req.wr = 1'b1;
        step();
        req.wr = 1'b0;
        // Writes outside normal state are dropped, and flags are read only.
        if (normal && a != ADDR_FLAGS) mreg[a[3:0]] = d & mask[a[3:0]];
    endtask
    task automatic check_regs();
        logic [7:0] v;
        foreach (mask[a]) begin
            step();
            req.addr = 8'(a);
            req.rd = 1'b1;
            step();
            req.rd = 1'b0;
            v = rdata;
            chk($sformatf("reg_%0h", a), v, mreg[a]);
        end
    endtask
    task automatic pulse(input bit wd);
        step();
        if (wd) wd_timeout = 1'b1;
        else rollover = 1'b1;
        step();
        wd_timeout = 1'b0;
        rollover = 1'b0;
    endtask
    task automatic power_down();
        rail_up = 1'b0;
        normal = 1'b0;
        sense_low = 1'b0;
        repeat (8) step();
        chk("fail_in_backup", {7'h0, fail}, 8'h00);
        chk("deselect_in_backup", {7'h0, deselect}, 8'h01);
    endtask
    task automatic power_up(input logic keep);
        int n;
        int lo;
        bit forced;
        n = 0;
        forced = 1'b0;
        sense_low = 1'b1;
        retained = keep;
        if (!keep) mreg = '{default: 8'h00};
        mreg[1] = keep ? mreg[1] : 8'h80;
        mreg[8] = keep ? (mreg[8] & 8'h80) : 8'h80;
        mreg[9] = 8'h00;
        mreg[10] = 8'h00;
        mreg[12] = 8'h40;
        mreg[15] = batt_low ? 8'h10 : 8'h00;
        lo = mreg[4][7] ? F_CY : (mreg[1][7] ? H_CY : N_CY);
        rail_up = 1'b1;
        while (deselect === 1'b1 && n < 2000) begin
            step();
            n++;
            if (fail === 1'b1) forced = 1'b1;
        end
        if (n >= 2000) begin
            n_mismatch++;
            conclude();
        end
        normal = 1'b1;
        chk("forced_high", {7'h0, forced}, 8'h01);
        chk("deselect_len", {7'h0, n >= lo && n <= lo + 14}, 8'h01);
        step();
        chk("follows_after", {7'h0, fail}, 8'h00);
        sense_low = 1'b0;
        check_regs();
    endtask
    initial begin
        repeat (5) step();
        chk("fail_reset", {7'h0, fail}, 8'h00);
        chk("deselect_reset", {7'h0, deselect}, 8'h01);
        reset_n = 1'b1;
        power_up(1'b0);
        repeat (8) begin
            sense_low = 1'(xs() & 32'h1);
            repeat (8) step();
            chk("fail_follow", {7'h0, fail}, {7'h0, ~sense_low});
        end
        sense_low = 1'b0;
        chk("pin_released", {7'h0, ev_oe}, 8'h00);
        wr(ADDR_CONTROL, 8'h00);
        chk("pin_low", {7'h0, ev_oe}, 8'h01);
        chk("pin_data", {7'h0, ev_o}, 8'h00);
        wr(ADDR_CONTROL, 8'h80);
        for (int en = 1; en >= 0; en--) begin
            wr(ADDR_CENTURY_HOURS, 8'(en << 7) | 8'(xs() & 32'h40));
            pulse(1'b0);
            if (en == 1) mreg[3] = mreg[3] ^ 8'h40;
            check_regs();
        end
        for (int s = 1; s >= 0; s--) begin
            wr(ADDR_WATCHDOG, 8'(s << 7) | 8'h01);
            wr(ADDR_ALARM_CTRL, 8'he0);
            wr(ADDR_CONTROL, 8'hc0);
            // With the pin busy, the cores' wish to pull low must reach it.
            core_low = 1'b1;
            step();
            chk("pin_core", {7'h0, ev_oe}, 8'h01);
            core_low = 1'b0;
            pulse(1'b1);
            if (s == 1) mreg[9] = 8'h00;
            if (s == 1) mreg[10] = 8'h00;
            if (s == 1) mreg[8] = 8'h80;
            check_regs();
        end
        wr(ADDR_WATCHDOG, 8'h00);
        wr(ADDR_ALARM_CTRL, 8'h00);
        wr(8'h05, 8'hff);
        wr(ADDR_FLAGS, 8'h00);
        for (int b = 0; b < 2; b++) begin
            batt_low = b[0];
            repeat (B_CY + 10) step();
            mreg[15] = b[0] ? 8'h10 : 8'h00;
            check_regs();
        end
        wr(ADDR_RECOVERY_DAY, 8'h80);
        wr(ADDR_SECONDS_HALT, 8'h00);
        wr(ADDR_CONTROL, 8'h40);
        wr(ADDR_HALT_UPDATE, 8'h00);
        power_down();
        batt_low = 1'b0;
        wr(ADDR_CONTROL, 8'h80);
        repeat (3 * B_CY) step();
        check_regs();
        power_up(1'b1);
        wr(ADDR_RECOVERY_DAY, 8'h00);
        power_down();
        power_up(1'b1);
        conclude();
    end
endmodule
`default_nettype wire
